// file: core/pfr_regulator.sv
/*
 * PID regulator producing the output-frequency command, with its
 * settings held in a classic Wishbone register file. Assumes all
 * analog and communication values come from logic on clk, already
 * scaled to 0..1000 (tenths of a percent of full scale).
 */
// Functional notes
// RL1 - Target source: pot 0, voltage 1, current 2, comm 3, keypad value 4.
// RL2 - The regulator acts only while the frequency source selection is 6.
// RL3 - Feedback source: pot 0, voltage 1, current 2, comm frequency 3.
// RL4 - Equal target and feedback source selections are refused.
// RL5 - The keypad target is 0.0 to 100.0 percent in tenths.
// RL6 - Operation selection 0 disables the regulator, 1 to 4 enable it.
// RL7 - Operations 1 and 3 differentiate the deviation.
// RL8 - Selections 2 and 4 take the derivative of the feedback alone.
// RL9 - Reverse selections make a positive deviation lower the output.
// RL10 - Deviation is target minus feedback times a gain of 0.00 to 10.00.
// RL11 - The proportional gain is 0.0 to 10.0 percent.
// RL12 - The integral time is 0.0 to 100.0 seconds.
// RL13 - The derivative time is 0.00 to 10.00 seconds.
// RL14 - The sum of the three terms is the frequency command while enabled.
`timescale 1ns/1ps
`default_nettype none
module pfr_regulator
   import pfr_pkg::*;
#(
   parameter int SAMPLE_CYCLES = SAMPLE_CYC
) (
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire pfr_wb_req_s wb_req,
   output logic             wb_ack,
   output logic [31:0]      wb_dat_o,
   input  wire logic [10:0] keypad_pot,
   input  wire logic [10:0] voltage_analog_input,
   input  wire logic [10:0] current_analog_input,
   input  wire logic [10:0] comm_target,
   input  wire logic [10:0] comm_freq,
   output logic [10:0]      freq_cmd,
   output logic             pid_active
);

   // ----------------------------------------------------------------
   // Arithmetic helpers
   // ----------------------------------------------------------------
   function automatic logic signed [31:0] muldiv(
      input logic signed [31:0] a,
      input logic signed [31:0] m,
      input logic signed [31:0] d);
      logic signed [31:0] r;
      r = 32'sh0;
      if (d != 32'sh0) begin
         r = (a * m) / d;
      end
      return r;
   endfunction : muldiv

   function automatic logic signed [31:0] sat(
      input logic signed [31:0] x,
      input logic signed [31:0] lo,
      input logic signed [31:0] hi);
      logic signed [31:0] r;
      r = x;
      if (x < lo) begin
         r = lo;
      end else if (x > hi) begin
         r = hi;
      end
      return r;
   endfunction : sat

   // ----------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------
   pfr_cfg_s    cfg;
   pfr_cfg_s    next_cfg;
   logic        refused;
   logic        next_refused;
   logic        next_wb_ack;
   logic [31:0] next_wb_dat_o;
   logic        req;
   logic        wr;
   logic [2:0]  w_tgt;
   logic [2:0]  w_fb;

   assign req = wb_req.cyc & wb_req.stb & ~wb_ack;
   assign wr  = req & wb_req.we & (wb_req.sel[1:0] == 2'h3);
   assign w_tgt = wb_req.dat[SRC_TGT_LSB +: 3];
   assign w_fb  = wb_req.dat[SRC_FB_LSB +: 3];

   // Out-of-range writes leave the old value, except freq_src in CTRL, and raise a sticky flag;
   // a new refusal in the clearing cycle wins over the clear.
   always_comb begin
      logic set_ref;
      logic clr_ref;
      set_ref = 1'b0;
      clr_ref = 1'b0;
      next_cfg = cfg;
      next_wb_ack = req;
      next_wb_dat_o = 32'h0;
      if (wr) begin
         unique case (wb_req.adr)
            ADR_CTRL: begin
               next_cfg.freq_src = wb_req.dat[CTRL_SRC_LSB +: 3];
               if (wb_req.dat[CTRL_OP_LSB +: 3] <= OP_MAX) begin // see RL6
                  next_cfg.op = wb_req.dat[CTRL_OP_LSB +: 3];
               end else begin
                  set_ref = 1'b1;
               end
            end
            ADR_SRC: begin
               if (w_tgt <= SEL_KEYPAD && w_fb <= SEL_COMM
                   && w_tgt != w_fb) begin // see RL4
                  next_cfg.tgt_sel = w_tgt;
                  next_cfg.fb_sel  = w_fb;
               end else begin
                  set_ref = 1'b1;
               end
            end
            ADR_TGT: begin
               if (wb_req.dat[15:0] <= TGT_MAX) begin // see RL5
                  next_cfg.tgt = wb_req.dat[15:0];
               end else begin
                  set_ref = 1'b1;
               end
            end
            ADR_GAIN: begin
               if (wb_req.dat[15:0] <= GAIN_MAX) begin // see RL10
                  next_cfg.gain = wb_req.dat[15:0];
               end else begin
                  set_ref = 1'b1;
               end
            end
            ADR_KP: begin
               if (wb_req.dat[15:0] <= KP_MAX) begin // see RL11
                  next_cfg.kp = wb_req.dat[15:0];
               end else begin
                  set_ref = 1'b1;
               end
            end
            ADR_TI: begin
               if (wb_req.dat[15:0] <= TI_MAX) begin // see RL12
                  next_cfg.ti = wb_req.dat[15:0];
               end else begin
                  set_ref = 1'b1;
               end
            end
            ADR_TD: begin
               if (wb_req.dat[15:0] <= TD_MAX) begin // see RL13
                  next_cfg.td = wb_req.dat[15:0];
               end else begin
                  set_ref = 1'b1;
               end
            end
            ADR_STAT: begin
               clr_ref = wb_req.dat[STAT_REF_BIT];
            end
            default: begin
            end
         endcase
      end
      if (req & ~wb_req.we) begin
         unique case (wb_req.adr)
            ADR_CTRL: begin
               next_wb_dat_o[CTRL_SRC_LSB +: 3] = cfg.freq_src;
               next_wb_dat_o[CTRL_OP_LSB +: 3]  = cfg.op;
            end
            ADR_SRC: begin
               next_wb_dat_o[SRC_TGT_LSB +: 3] = cfg.tgt_sel;
               next_wb_dat_o[SRC_FB_LSB +: 3]  = cfg.fb_sel;
            end
            ADR_TGT:  next_wb_dat_o[15:0] = cfg.tgt;
            ADR_GAIN: next_wb_dat_o[15:0] = cfg.gain;
            ADR_KP:   next_wb_dat_o[15:0] = cfg.kp;
            ADR_TI:   next_wb_dat_o[15:0] = cfg.ti;
            ADR_TD:   next_wb_dat_o[15:0] = cfg.td;
            ADR_STAT: begin
               next_wb_dat_o[10:0]         = freq_cmd;
               next_wb_dat_o[STAT_ACT_BIT] = pid_active;
               next_wb_dat_o[STAT_REF_BIT] = refused;
            end
            default: next_wb_dat_o = 32'h0;
         endcase
      end
      next_refused = (refused & ~clr_ref) | set_ref;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         cfg <= '{freq_src: 3'h0, op: OP_OFF, tgt_sel: RST_TGT_SEL,
                  fb_sel: RST_FB_SEL, tgt: 16'h0, gain: RST_GAIN,
                  kp: RST_KP, ti: RST_TI, td: 16'h0};
         refused  <= 1'b0;
         wb_ack   <= 1'b0;
         wb_dat_o <= 32'h0;
      end else begin
         cfg      <= next_cfg;
         refused  <= next_refused;
         wb_ack   <= next_wb_ack;
         wb_dat_o <= next_wb_dat_o;
      end
   end

   // ----------------------------------------------------------------
   // Control loop, one step per sample tick
   // ----------------------------------------------------------------
   logic [31:0]        cnt;
   logic [31:0]        next_cnt;
   logic               tick;
   logic signed [31:0] acc;
   logic signed [31:0] next_acc;
   logic signed [31:0] x_prev;
   logic signed [31:0] next_x_prev;
   logic [10:0]        next_freq_cmd;
   logic               next_pid_active;
   logic signed [31:0] tgt_v;
   logic signed [31:0] fb_v;
   logic signed [31:0] fbs;
   logic signed [31:0] dev;
   logic signed [31:0] u;
   logic signed [31:0] cmd;
   logic               enabled;
   logic               reverse;

   assign tick = (cnt == 32'(SAMPLE_CYCLES - 1));
   assign enabled = (cfg.op != OP_OFF) && (cfg.op <= OP_MAX)
                    && (cfg.freq_src == FREQ_SRC_PID); // see RL2, RL6
   assign reverse = (cfg.op == 3'h3) || (cfg.op == 3'h4);

   always_comb begin
      logic signed [31:0] p;
      logic signed [31:0] i;
      logic signed [31:0] d;
      logic signed [31:0] x;
      logic signed [31:0] lim;
      logic signed [31:0] acc_n;
      p = 32'sh0;
      i = 32'sh0;
      d = 32'sh0;
      x = 32'sh0;
      lim = 32'sh0;
      acc_n = 32'sh0;
      unique case (cfg.tgt_sel) // see RL1
         SEL_POT:  tgt_v = 32'(keypad_pot);
         SEL_VOLT: tgt_v = 32'(voltage_analog_input);
         SEL_CUR:  tgt_v = 32'(current_analog_input);
         SEL_COMM: tgt_v = 32'(comm_target);
         default:  tgt_v = 32'(cfg.tgt);
      endcase
      unique case (cfg.fb_sel) // see RL3
         SEL_POT:  fb_v = 32'(keypad_pot);
         SEL_VOLT: fb_v = 32'(voltage_analog_input);
         SEL_CUR:  fb_v = 32'(current_analog_input);
         default:  fb_v = 32'(comm_freq);
      endcase
      fbs = muldiv(fb_v, 32'(cfg.gain), GAIN_DIV); // see RL10
      dev = tgt_v - fbs;
      p = muldiv(dev, 32'(cfg.kp), KP_DIV); // see RL11
      // A zero integral time switches the integral term off.
      lim = 32'(cfg.ti) * TI_SAMP * CMD_MAX;
      acc_n = sat(acc + dev, -lim, lim); // see RL12
      i = muldiv(acc_n, 32'sh1, 32'(cfg.ti) * TI_SAMP);
      if (cfg.op == 3'h1 || cfg.op == 3'h3) begin
         x = dev; // see RL7
      end else begin
         x = -fbs; // see RL8
      end
      d = (x - x_prev) * 32'(cfg.td) * TD_SAMP; // see RL13
      u = p + i + d;
      if (reverse) begin
         u = -u; // see RL9
      end
      cmd = sat(u, 32'sh0, CMD_MAX);
      next_cnt = tick ? 32'h0 : cnt + 32'h1;
      next_acc = acc;
      next_x_prev = x_prev;
      next_freq_cmd = freq_cmd;
      next_pid_active = pid_active;
      if (tick) begin
         next_x_prev = x;
         next_pid_active = enabled;
         next_acc = enabled ? acc_n : 32'sh0;
         next_freq_cmd = enabled ? cmd[10:0] : 11'h0; // see RL14
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         cnt        <= 32'h0;
         acc        <= 32'sh0;
         x_prev     <= 32'sh0;
         freq_cmd   <= 11'h0;
         pid_active <= 1'b0;
      end else begin
         cnt        <= next_cnt;
         acc        <= next_acc;
         x_prev     <= next_x_prev;
         freq_cmd   <= next_freq_cmd;
         pid_active <= next_pid_active;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);

   sequence s_step;
      tick && enabled;
   endsequence

   sequence s_src_write;
      wr && wb_req.adr == ADR_SRC && w_tgt == w_fb;
   endsequence

   a_src_distinct: assert property (cfg.tgt_sel != cfg.fb_sel) // see RL4
      else $error("target and feedback sources are equal");
   a_src_refused: assert property (s_src_write |=> // see RL4
      $stable(cfg.tgt_sel) && $stable(cfg.fb_sel) && refused)
      else $error("equal source write was taken");
   a_tgt_range: assert property (cfg.tgt <= TGT_MAX) // see RL5
      else $error("keypad target out of range");
   a_gain_range: assert property (cfg.gain <= GAIN_MAX) // see RL10
      else $error("feedback gain out of range");
   a_kp_range: assert property (cfg.kp <= KP_MAX) // see RL11
      else $error("proportional gain out of range");
   a_ti_range: assert property (cfg.ti <= TI_MAX) // see RL12
      else $error("integral time out of range");
   a_td_range: assert property (cfg.td <= TD_MAX) // see RL13
      else $error("derivative time out of range");
   a_off_zero: assert property (tick && cfg.op == OP_OFF |=> // see RL6
      freq_cmd == 11'h0 && !pid_active)
      else $error("disabled regulator drives a command");
   a_src_gate: assert property ( // see RL2
      tick && cfg.freq_src != FREQ_SRC_PID |=> freq_cmd == 11'h0)
      else $error("regulator acts while not selected");
   a_cmd_sum: assert property (s_step |=> // see RL14
      pid_active && freq_cmd == $past(cmd[10:0]))
      else $error("command is not the clamped term sum");
   a_rev_sign: assert property ( // see RL9
      s_step ##0 reverse && dev > 32'sh0 && cfg.kp != 16'h0
      && cfg.ti == 16'h0 && cfg.td == 16'h0 |=> freq_cmd == 11'h0)
      else $error("reverse mode raised output on positive deviation");
   a_ack_pulse: assert property (wb_ack |=> !wb_ack)
      else $error("bus answer held longer than one cycle");

endmodule : pfr_regulator
`default_nettype wire

// file: include/pfr_pkg.sv
/*
 * Constants, register map and carrier types of the PID frequency
 * regulator. Assumes a 20 MHz control clock and a 32-bit classic
 * Wishbone register bus with byte addresses.
 */
`default_nettype none
package pfr_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_NS     = 50;
   localparam int SAMPLE_NS  = 1000000;
   localparam int SAMPLE_CYC = (SAMPLE_NS + CLK_NS - 1) / CLK_NS;
   // Integral time counts tenths of a second, derivative time hundredths.
   localparam int TI_UNIT_NS = 100000000;
   localparam int TD_UNIT_NS = 10000000;
   localparam int TI_SAMP    = TI_UNIT_NS / SAMPLE_NS;
   localparam int TD_SAMP    = TD_UNIT_NS / SAMPLE_NS;

   // ----------------------------------------------------------------
   // Register offsets and fields
   // ----------------------------------------------------------------
   localparam logic [7:0] ADR_CTRL = 8'h00;
   localparam logic [7:0] ADR_SRC  = 8'h04;
   localparam logic [7:0] ADR_TGT  = 8'h08;
   localparam logic [7:0] ADR_GAIN = 8'h0c;
   localparam logic [7:0] ADR_KP   = 8'h10;
   localparam logic [7:0] ADR_TI   = 8'h14;
   localparam logic [7:0] ADR_TD   = 8'h18;
   localparam logic [7:0] ADR_STAT = 8'h1c;
   localparam int CTRL_SRC_LSB = 0;
   localparam int CTRL_OP_LSB  = 4;
   localparam int SRC_TGT_LSB  = 0;
   localparam int SRC_FB_LSB   = 4;
   localparam int STAT_ACT_BIT = 16;
   localparam int STAT_REF_BIT = 17;

   // ----------------------------------------------------------------
   // Encodings and limits
   // ----------------------------------------------------------------
   localparam logic [2:0] FREQ_SRC_PID = 3'h6;
   localparam logic [2:0] OP_OFF       = 3'h0;
   localparam logic [2:0] OP_MAX       = 3'h4;
   localparam logic [2:0] SEL_POT      = 3'h0;
   localparam logic [2:0] SEL_VOLT     = 3'h1;
   localparam logic [2:0] SEL_CUR      = 3'h2;
   localparam logic [2:0] SEL_COMM     = 3'h3;
   localparam logic [2:0] SEL_KEYPAD   = 3'h4;
   localparam logic [15:0] TGT_MAX     = 16'h03e8;
   localparam logic [15:0] GAIN_MAX    = 16'h03e8;
   localparam logic [15:0] KP_MAX      = 16'h0064;
   localparam logic [15:0] TI_MAX      = 16'h03e8;
   localparam logic [15:0] TD_MAX      = 16'h03e8;
   localparam int GAIN_DIV = 100;
   localparam int KP_DIV   = 1000;
   localparam int CMD_MAX  = 1000;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [2:0]  RST_TGT_SEL = 3'h4;
   localparam logic [2:0]  RST_FB_SEL  = 3'h1;
   localparam logic [15:0] RST_GAIN    = 16'h0064;
   localparam logic [15:0] RST_KP      = 16'h000a;
   localparam logic [15:0] RST_TI      = 16'h000a;

   typedef struct packed {
      logic [2:0]  freq_src;
      logic [2:0]  op;
      logic [2:0]  tgt_sel;
      logic [2:0]  fb_sel;
      logic [15:0] tgt;
      logic [15:0] gain;
      logic [15:0] kp;
      logic [15:0] ti;
      logic [15:0] td;
   } pfr_cfg_s;

   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [7:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } pfr_wb_req_s;

endpackage : pfr_pkg
`default_nettype wire

// file: verif/pfr_src_model.sv
/*
 * Behavioural model of the analog inputs, keypad pot and
 * communication setpoints feeding the regulator.
 * Assumes the bench loads new levels one at a time on clk.
 */
`timescale 1ns/1ps
`default_nettype none
module pfr_src_model (
   input  wire logic        clk,
   input  wire logic        set_en,
   input  wire logic [2:0]  set_idx,
   input  wire logic [10:0] set_val,
   output logic [10:0]      keypad_pot,
   output logic [10:0]      voltage_analog_input,
   output logic [10:0]      current_analog_input,
   output logic [10:0]      comm_target,
   output logic [10:0]      comm_freq
);
   // Distinct levels so that every source selection shows in the result.
   // One process owns every level, so each output has a single driver.
   initial begin
      keypad_pot           = 11'h0c8;
      voltage_analog_input = 11'h190;
      current_analog_input = 11'h258;
      comm_target          = 11'h320;
      comm_freq            = 11'h064;
      forever begin
         @(posedge clk);
         if (set_en) begin
            case (set_idx)
               3'h0: keypad_pot <= set_val;
               3'h1: voltage_analog_input <= set_val;
               3'h2: current_analog_input <= set_val;
               3'h3: comm_target <= set_val;
               default: comm_freq <= set_val;
            endcase
         end
      end
   end
endmodule : pfr_src_model
`default_nettype wire

// file: verif/pid_frequency_regulator_tb.sv
/*
 * Self-checking bench of the PID frequency regulator.
 * Assumes SAMPLE_CYCLES is shortened to 8 so a tick is 8 clocks.
 */
`timescale 1ns/1ps
`default_nettype none
module pid_frequency_regulator_tb
   import pfr_pkg::*;
;
   logic        clk = 1'b0;
   logic        srst = 1'b1;
   pfr_wb_req_s wb_req = '0;
   logic        wb_ack;
   logic [31:0] wb_dat_o;
   logic [10:0] pot, volt, cur, ctgt, cfrq, freq_cmd, p;
   logic        pid_active;
   logic        set_en = 1'b0;
   logic [2:0]  set_idx = 3'h0;
   logic [10:0] set_val = 11'h000;
   logic [31:0] r, a;
   int          bad_count = 0;
   int          checked = 0;
   // tgt_sel, fb_sel, op, gain, kp, expected freq_cmd
   int rows [6][6] = '{'{4,1,1,100,100,10}, '{0,3,2,50,100,15},
      '{1,2,3,100,100,20}, '{2,0,4,100,50,0}, '{3,0,1,300,100,20},
      '{4,3,3,1000,100,50}};
   logic [7:0]  badr [7] = '{ADR_TGT, ADR_GAIN, ADR_KP, ADR_TI, ADR_TD,
      ADR_SRC, ADR_CTRL};
   logic [31:0] bval [7] = '{32'h3e9, 32'h3e9, 32'h65, 32'h3e9, 32'h3e9,
      32'h22, 32'h50};
   logic [7:0]  radr [9] = '{ADR_CTRL, ADR_SRC, ADR_TGT, ADR_GAIN, ADR_KP,
      ADR_TI, ADR_TD, ADR_STAT, 8'h20};
   logic [31:0] rval [9] = '{32'h0, 32'h14, 32'h0, 32'h64, 32'h0a, 32'h0a,
      32'h0, 32'h0, 32'h0};

   always #25 clk = ~clk;

   pfr_regulator #(.SAMPLE_CYCLES(8)) i_dut (.clk(clk), .srst(srst),
      .wb_req(wb_req), .wb_ack(wb_ack), .wb_dat_o(wb_dat_o),
      .keypad_pot(pot), .voltage_analog_input(volt),
      .current_analog_input(cur), .comm_target(ctgt), .comm_freq(cfrq),
      .freq_cmd(freq_cmd), .pid_active(pid_active));

   pfr_src_model i_src (.clk(clk), .set_en(set_en), .set_idx(set_idx),
      .set_val(set_val), .keypad_pot(pot), .voltage_analog_input(volt),
      .current_analog_input(cur), .comm_target(ctgt), .comm_freq(cfrq));

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      checked++;
      if (g !== e) begin
         bad_count++;
         $display("unexpected %s: expected %h, seen %h", nm, e, g);
      end
   endtask : chk

   task automatic summarize();
      $display("checked %0d, bad_count %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : summarize

   // The request is held until ack is sampled, then dropped for a cycle.
   task automatic wb(input logic we, input logic [7:0] ad,
                     input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      wb_req <= '{cyc:1'b1, stb:1'b1, we:we, adr:ad, sel:4'hf, dat:d};
      do begin
         @(posedge clk);
         n++;
      end while (wb_ack !== 1'b1 && n < 20);
      chk("wb_ack", 32'h1, {31'h0, wb_ack});
      q = wb_dat_o;
      wb_req <= '0;
      @(posedge clk);
   endtask : wb

   task automatic wr(input logic [7:0] ad, input int d);
      logic [31:0] q;
      wb(1'b1, ad, d, q);
   endtask : wr

   task automatic src_set(input logic [2:0] i, input logic [10:0] v);
      set_en  <= 1'b1;
      set_idx <= i;
      set_val <= v;
      @(posedge clk);
      set_en <= 1'b0;
   endtask : src_set

   task automatic peak(output logic [10:0] m);
      m = 11'h000;
      repeat (24) begin
         @(posedge clk);
         if (freq_cmd > m) m = freq_cmd;
      end
   endtask : peak

   function automatic logic [10:0] exp_cmd(int t, int f, int g, int kp,
                                           int op);
      int u;
      u = (t - f * g / 100) * kp / 1000;
      if (op >= 3) u = -u;
      if (u < 0) u = 0;
      if (u > CMD_MAX) u = CMD_MAX;
      return 11'(u);
   endfunction : exp_cmd

   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      summarize();
   end

   initial begin
      repeat (6) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      wr(ADR_TGT, 500);
      wr(ADR_TI, 0);
      foreach (rows[k]) begin
         wr(ADR_SRC, rows[k][1] * 16 + rows[k][0]);
         wr(ADR_CTRL, rows[k][2] * 16 + 6);
         wr(ADR_GAIN, rows[k][3]);
         wr(ADR_KP, rows[k][4]);
         repeat (24) @(posedge clk);
         chk("freq_cmd", rows[k][5], freq_cmd);
         chk("pid_active", 32'h1, pid_active);
      end
      wr(ADR_CTRL, 8'h15);
      repeat (24) @(posedge clk);
      chk("freq_cmd src 5", 32'h0, freq_cmd);
      chk("pid_active src 5", 32'h0, pid_active);
      wr(ADR_CTRL, 8'h06);
      repeat (24) @(posedge clk);
      chk("pid_active op 0", 32'h0, pid_active);
      chk("freq_cmd op 0", 32'h0, freq_cmd);
      srst <= 1'b1;
      repeat (6) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      chk("freq_cmd reset", 32'h0, freq_cmd);
      foreach (radr[k]) begin
         wb(1'b0, radr[k], 0, r);
         chk("reset value", rval[k], r);
      end
      foreach (badr[k]) begin
         wb(1'b0, badr[k], 0, a);
         wr(badr[k], bval[k]);
         wb(1'b0, badr[k], 0, r);
         chk("refused write", a, r);
         wb(1'b0, ADR_STAT, 0, r);
         chk("refused flag", 32'h1, r[STAT_REF_BIT]);
         wr(ADR_STAT, 32'h20000);
         wb(1'b0, ADR_STAT, 0, r);
         chk("refused clear", 32'h0, r[STAT_REF_BIT]);
      end
      // Derivative only: a one-tick spike of delta times 10.
      wr(ADR_KP, 0);
      wr(ADR_TI, 0);
      wr(ADR_TD, 1);
      wr(ADR_SRC, 8'h04);
      wr(ADR_TGT, 500);
      wr(ADR_CTRL, 8'h16);
      repeat (24) @(posedge clk);
      wr(ADR_TGT, 550);
      peak(p);
      chk("d on deviation", 32'd500, p);
      wr(ADR_CTRL, 8'h26);
      repeat (24) @(posedge clk);
      wr(ADR_TGT, 600);
      peak(p);
      chk("d ignores target", 32'h0, p);
      src_set(3'h0, 11'd150);
      peak(p);
      chk("d on feedback", 32'd500, p);
      // Integral only: dev 1000, TI 0.1 s gives 10 per tick.
      wr(ADR_TD, 0);
      wr(ADR_GAIN, 0);
      wr(ADR_TGT, 1000);
      wr(ADR_TI, 1);
      wr(ADR_CTRL, 8'h06);
      wr(ADR_CTRL, 8'h16);
      repeat (24) @(posedge clk);
      a = freq_cmd;
      repeat (80) @(posedge clk);
      chk("integral slope", a + 100, freq_cmd);
      wr(ADR_KP, 100);
      wr(ADR_TI, 0);
      wr(ADR_GAIN, 200);
      repeat (24) @(posedge clk);
      chk("gain and kp", exp_cmd(1000, 150, 200, 100, 1),
          freq_cmd);
      summarize();
   end
endmodule : pid_frequency_regulator_tb
`default_nettype wire
